// ---- logic/eeprom_slave.sv ----
// two-wire serial memory slave: protocol, page buffer, memory array
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT,
  parameter bit HAS_STRAPS = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_wp,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  output logic o_prog_busy
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rst_pipe;
  logic rst_core_n;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_pipe <= SYNC_RST_VAL;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_core_n = rst_pipe[1];

  // ************************************************************
  // link side capture
  // ************************************************************
  logic link_bit;
  logic link_tgl;

  eeprom_link_capture u_link (
    .i_scl_clk (i_scl),
    .i_rst_n (i_rst_n),
    .i_sda (i_sda_i),
    .o_bit (link_bit),
    .o_tgl (link_tgl)
  );

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  bus_pins_type pins_s1;
  bus_pins_type pins_s2;
  bus_pins_type pins_prev;
  logic [2:0] tgl_sync;
  logic [3:0] side_s1;
  logic [3:0] side_s2;

  always_ff @(posedge i_core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pins_s1 <= '1;
      pins_s2 <= '1;
      pins_prev <= '1;
      tgl_sync <= 3'h0;
      side_s1 <= 4'h0;
      side_s2 <= 4'h0;
    end else if (i_ce) begin
      pins_s1 <= '{scl: i_scl, sda: i_sda_i};
      pins_s2 <= pins_s1;
      pins_prev <= pins_s2;
      tgl_sync <= {tgl_sync[1:0], link_tgl};
      side_s1 <= {i_wp, i_addr_strap_bit2, i_addr_strap_bit1,
                  i_addr_strap_bit0};
      side_s2 <= side_s1;
    end
  end

  // ************************************************************
  // bus events
  // ************************************************************
  logic start_evt;
  logic stop_evt;
  logic fall_evt;
  logic rise_evt;
  logic wp_level;
  logic [2:0] strap_sel;

  assign start_evt = pins_prev.scl & pins_s2.scl & pins_prev.sda
                     & ~pins_s2.sda;
  assign stop_evt = pins_prev.scl & pins_s2.scl & ~pins_prev.sda
                    & pins_s2.sda;
  assign fall_evt = pins_prev.scl & ~pins_s2.scl;
  assign rise_evt = tgl_sync[2] ^ tgl_sync[1];
  assign wp_level = side_s2[3];
  assign strap_sel = HAS_STRAPS ? side_s2[2:0] : NO_STRAP_SEL;

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;

  // ************************************************************
  // protocol state
  // ************************************************************
  state_type state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [4:0] addr_hi;
  logic [MEM_ADDR_W-1:0] cur_addr;
  logic read_dir;
  logic wp_latched;
  logic master_ack;
  logic [PROG_CNT_W-1:0] prog_cnt;
  logic byte_done;
  logic dev_match;
  logic load_byte;
  logic clr_valid;
  logic prog_done;
  logic [7:0] rd_byte;

  assign byte_done = fall_evt && (bit_cnt == BITS_PER_BYTE);
  assign dev_match = (rx_shift[7:4] == DEV_TYPE_CODE)
                     && (rx_shift[3:1] == strap_sel);
  assign load_byte = (state == ST_RX) && byte_done
                     && (byte_idx == IDX_DATA) && !wp_latched
                     && !start_evt && !stop_evt;
  assign prog_done = (state == ST_BUSY)
                     && (prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1));
  assign clr_valid = prog_done || (start_evt && state != ST_BUSY);
  assign rd_byte = mem[cur_addr];

  always_ff @(posedge i_core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= IDX_DEV_ADDR;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      addr_hi <= 5'h00;
      cur_addr <= ADDR_RST_VAL;
      read_dir <= 1'b0;
      wp_latched <= 1'b0;
      master_ack <= 1'b0;
      prog_cnt <= '0;
      o_sda_oe <= 1'b0;
    end else if (i_ce) begin
      if (state == ST_BUSY) begin
        o_sda_oe <= 1'b0;
        prog_cnt <= prog_cnt + 1'b1;
        if (prog_done) begin
          state <= ST_IDLE;
          prog_cnt <= '0;
        end
      end else if (stop_evt) begin
        o_sda_oe <= 1'b0;
        if (|page_valid) begin
          state <= ST_BUSY;
          prog_cnt <= '0;
        end else begin
          state <= ST_IDLE;
        end
      end else if (start_evt) begin
        state <= ST_RX;
        bit_cnt <= 4'h0;
        byte_idx <= IDX_DEV_ADDR;
        o_sda_oe <= 1'b0;
        wp_latched <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (rise_evt && bit_cnt != BITS_PER_BYTE) begin
              rx_shift <= {rx_shift[6:0], link_bit};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (byte_done) begin
              case (byte_idx)
                IDX_DEV_ADDR: begin
                  if (dev_match) begin
                    o_sda_oe <= 1'b1;
                    read_dir <= rx_shift[0];
                    state <= ST_RX_ACK;
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                IDX_ADDR_HI: begin
                  addr_hi <= rx_shift[4:0];
                  o_sda_oe <= 1'b1;
                  state <= ST_RX_ACK;
                end
                IDX_ADDR_LO: begin
                  cur_addr <= {addr_hi, rx_shift};
                  o_sda_oe <= 1'b1;
                  state <= ST_RX_ACK;
                end
                default: begin
                  if (wp_latched) begin
                    state <= ST_IDLE;
                  end else begin
                    cur_addr <= {cur_addr[12:5],
                                 cur_addr[4:0] + 5'h01};
                    o_sda_oe <= 1'b1;
                    state <= ST_RX_ACK;
                  end
                end
              endcase
            end
          end
          ST_RX_ACK: begin
            if (fall_evt) begin
              bit_cnt <= 4'h0;
              if (byte_idx == IDX_ADDR_LO) begin
                wp_latched <= wp_level;
              end
              if (byte_idx == IDX_DEV_ADDR && read_dir) begin
                o_sda_oe <= ~rd_byte[7];
                tx_shift <= {rd_byte[6:0], 1'b0};
                state <= ST_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state <= ST_RX;
                if (byte_idx != IDX_DATA) begin
                  byte_idx <= byte_idx + 1'b1;
                end
              end
            end
          end
          ST_TX: begin
            if (rise_evt) begin
              bit_cnt <= bit_cnt + 1'b1;
            end else if (byte_done) begin
              o_sda_oe <= 1'b0;
              cur_addr <= cur_addr + 1'b1;
              master_ack <= 1'b0;
              state <= ST_TX_ACK;
            end else if (fall_evt) begin
              o_sda_oe <= ~tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
          ST_TX_ACK: begin
            if (rise_evt) begin
              if (link_bit) begin
                state <= ST_IDLE;
              end else begin
                master_ack <= 1'b1;
              end
            end else if (fall_evt && master_ack) begin
              bit_cnt <= 4'h0;
              o_sda_oe <= ~rd_byte[7];
              tx_shift <= {rd_byte[6:0], 1'b0};
              state <= ST_TX;
            end
          end
          default: begin
            state <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // page buffer
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      page_valid <= '0;
    end else if (i_ce) begin
      if (clr_valid) begin
        page_valid <= '0;
      end else if (load_byte) begin
        page_valid[cur_addr[4:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_ce && load_byte) begin
      page_buf[cur_addr[4:0]] <= rx_shift;
    end
  end

  // ************************************************************
  // memory array and commit
  // ************************************************************
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_ce && state == ST_BUSY && prog_cnt < PROG_CNT_W'(PAGE_BYTES)
        && page_valid[prog_cnt[4:0]]) begin
      mem[{cur_addr[12:5], prog_cnt[4:0]}] <= page_buf[prog_cnt[4:0]];
    end
  end

  // ************************************************************
  // constant pin level and status
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      o_sda_o <= 1'b0;
      o_prog_busy <= 1'b0;
    end else if (i_ce) begin
      o_sda_o <= 1'b0;
      o_prog_busy <= (state == ST_BUSY);
    end
  end

endmodule : eeprom_slave
`default_nettype wire

// ---- logic/eeprom_pkg.sv ----
// shared constants, types and states of the serial memory slave
package eeprom_pkg;

  // ************************************************************
  // memory geometry
  // ************************************************************
  localparam int MEM_ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int PAGE_OFS_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ************************************************************
  // slave address layout
  // ************************************************************
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam logic [2:0] NO_STRAP_SEL = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_DEV_ADDR = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_CLK_MHZ = 100;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_US * CORE_CLK_MHZ;
  localparam int PROG_CNT_W = 24;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] SYNC_RST_VAL = 2'h0;
  localparam logic [MEM_ADDR_W-1:0] ADDR_RST_VAL = 13'h0000;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_RX     = 6'b00_0010,
    ST_RX_ACK = 6'b00_0100,
    ST_TX     = 6'b00_1000,
    ST_TX_ACK = 6'b01_0000,
    ST_BUSY   = 6'b10_0000
  } state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_type;

endpackage : eeprom_pkg

// ---- logic/eeprom_link_capture.sv ----
// data bit capture on the serial clock rising edge
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_capture
  import eeprom_pkg::*;
(
  input wire logic i_scl_clk,
  input wire logic i_rst_n,
  input wire logic i_sda,
  output logic o_bit,
  output logic o_tgl
);

  // ************************************************************
  // sample on rising edge, flag each edge by a toggle
  // ************************************************************
  always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit <= 1'b1;
      o_tgl <= 1'b0;
    end else begin
      o_bit <= i_sda;
      o_tgl <= ~o_tgl;
    end
  end

endmodule : eeprom_link_capture
`default_nettype wire

// ---- testbench/eeprom_slave_chk.sv ----
// assertion checker for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module eeprom_slave_chk
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_wp,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  input wire logic o_prog_busy
);
  logic [23:0] busy_cnt;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= o_prog_busy ? busy_cnt + 24'h00_0001 : '0;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_OPEN_DRAIN: assert property (o_sda_oe |-> !o_sda_o)
    else $error("driven data value not low");
  AST_BUSY_SILENT: assert property (o_prog_busy |-> !o_sda_oe)
    else $error("line driven while programming");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !i_rst_n |=> !o_sda_oe && !o_prog_busy)
    else $error("not idle in reset");
  AST_PROG_LEN: assert property ($fell(o_prog_busy) |->
    busy_cnt == PROG_CYCLES)
    else $error("programming length wrong");
  AST_PROG_AT_STOP: assert property ($rose(o_prog_busy) |->
    i_scl && i_sda_i)
    else $error("programming began outside idle bus");
  AST_DRIVE_HOLD: assert property ($rose(o_sda_oe) |=> o_sda_oe[*3])
    else $error("low drive too short");
  AST_CHANGE_AFTER_FALL: assert property ($changed(o_sda_oe) |->
    !$past(i_scl, 2) && $past(i_scl, 5))
    else $error("data change not after clock fall");
  AST_WP_NO_PROG: assert property ($rose(o_prog_busy) |->
    !$past(i_wp, 8))
    else $error("programming while protected");
endmodule : eeprom_slave_chk
bind eeprom_slave eeprom_slave_chk #(.PROG_CYCLES(PROG_CYCLES))
  eeprom_slave_chk_i (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_scl(i_scl),
    .i_sda_i(i_sda_i),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .i_wp(i_wp),
    .i_addr_strap_bit0(i_addr_strap_bit0),
    .i_addr_strap_bit1(i_addr_strap_bit1),
    .i_addr_strap_bit2(i_addr_strap_bit2),
    .o_prog_busy(o_prog_busy)
  );
`default_nettype wire

// ---- testbench/link_master.sv ----
// behavioural two-wire bus master
`timescale 1ns/1ps
`default_nettype none
module link_master #(
  parameter int HI = 28,
  parameter int LO = 36
) (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #(LO / 2);
    o_scl = 1'b1;
    #(HI - 2);
    r = i_sda;
    #2;
    o_scl = 1'b0;
    #(LO / 2);
  endtask : bit_io
  task automatic start();
    o_sda_low = 1'b0;
    #(LO / 2);
    o_scl = 1'b1;
    #HI;
    o_sda_low = 1'b1;
    #HI;
    o_scl = 1'b0;
    #(LO / 2);
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    #(LO / 2);
    o_scl = 1'b1;
    #HI;
    o_sda_low = 1'b0;
    #(HI * 2);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, r);
  endtask : rbyte
  task automatic poll(input logic [7:0] a, output logic ack);
    ack = 1'b0;
    for (int n = 0; n < 40 && !ack; n++) begin
      start();
      wbyte(a, ack);
      if (!ack) begin
        stop();
      end
    end
  endtask : poll
endmodule : link_master
`default_nettype wire

// ---- testbench/eeprom_slave_test.sv ----
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  bad_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module eeprom_slave_test;
  import eeprom_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] DEV_W = {DEV_TYPE_CODE, STRAP, 1'b0};
  localparam logic [7:0] DEV_R = {DEV_TYPE_CODE, STRAP, 1'b1};
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wp = 1'b0;
  logic [2:0] strap = STRAP;
  logic scl, m_low, sda_oe, sda_o, busy;
  wire logic sda;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  assign sda = !(m_low || sda_oe);
  always #5 i_core_clk = !i_core_clk;
  eeprom_slave #(.PROG_CYCLES(200)) eeprom_slave_i (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_wp(i_wp), .i_addr_strap_bit0(strap[0]),
    .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
    .o_prog_busy(busy));
  link_master link_master_i (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
  task automatic complete_run();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic set_addr(input logic [15:0] a);
    logic ack;
    link_master_i.poll(DEV_W, ack);
    `CHK(ack, 1'b1)
    link_master_i.wbyte(a[15:8], ack);
    `CHK(ack, 1'b1)
    link_master_i.wbyte(a[7:0], ack);
    `CHK(ack, 1'b1)
  endtask : set_addr
  task automatic read_chk(input logic [15:0] a, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] d;
    set_addr(a);
    link_master_i.start();
    link_master_i.wbyte(DEV_R, ack);
    `CHK(ack, 1'b1)
    foreach (e[i]) begin
      link_master_i.rbyte(i < e.size() - 1, d);
      `CHK(d, e[i])
    end
    link_master_i.stop();
  endtask : read_chk
  task automatic t_addr();
    logic ack;
    logic [7:0] flip[4] = '{8'h02, 8'h04, 8'h08, 8'h80};
    foreach (flip[i]) begin
      link_master_i.start();
      link_master_i.wbyte(DEV_W ^ flip[i], ack);
      `CHK(ack, 1'b0)
      link_master_i.stop();
    end
  endtask : t_addr
  task automatic t_page();
    logic ack;
    logic [7:0] e[$];
    set_addr(16'he01e);
    for (int k = 0; k < 34; k++) begin
      link_master_i.wbyte(8'(k + 1), ack);
      `CHK(ack, 1'b1)
      e.push_back(8'(k + 3));
    end
    link_master_i.stop();
    `CHK(busy, 1'b1)
    link_master_i.start();
    link_master_i.wbyte(DEV_W, ack);
    `CHK(ack, 1'b0)
    link_master_i.stop();
    read_chk(16'h0000, e[0:31]);
  endtask : t_page
  task automatic t_wp();
    logic ack;
    @(negedge i_core_clk) i_wp = 1'b1;
    set_addr(16'h0005);
    link_master_i.wbyte(8'h00, ack);
    `CHK(ack, 1'b0)
    link_master_i.stop();
    @(negedge i_core_clk) i_wp = 1'b0;
    read_chk(16'h0005, {8'h08});
  endtask : t_wp
  task automatic t_wrap();
    logic ack;
    logic [7:0] d;
    read_chk(16'h1fff, {8'hff, 8'h03});
    link_master_i.start();
    link_master_i.wbyte(DEV_R, ack);
    `CHK(ack, 1'b1)
    link_master_i.rbyte(1'b0, d);
    `CHK(d, 8'h04)
    `CHK(sda_o, 1'b0)
    link_master_i.stop();
  endtask : t_wrap
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    repeat (10) @(negedge i_core_clk);
    read_chk(16'h1234, {8'hff, 8'hff});
    t_addr();
    t_page();
    t_wp();
    t_wrap();
    complete_run();
  end
endmodule : eeprom_slave_test
`default_nettype wire
